/* rtl/cap_pkg.sv */
`default_nettype none
package cap_pkg;
  // register byte addresses, chosen for this block
  localparam logic [11:0] CAP_FIRST_ADDR = 12'h080;
  localparam logic [11:0] CAP_SECOND_ADDR = 12'h084;
  localparam logic [11:0] PORT_SEL_ADDR = 12'h088;
  localparam logic [11:0] LINK_STATUS_ADDR = 12'h08C;
  // field positions in the first capability register
  localparam int HOLD_BIT = 7;
  localparam int MODE_LSB_BIT = 6;
  localparam int FREQ_BIT = 5;
  localparam int EQ_BIT = 4;
  localparam int DUAL_CAP_BIT = 3;
  localparam int CHANNEL_BIT = 2;
  localparam int GPIO_FC_BIT = 1;
  localparam int AUDIO_BIT = 0;
  localparam logic [7:0] CAP_RESET = 8'h00;
  localparam logic [1:0] MODE_HI_RESET = 2'h0;
  // decoded control-channel modes
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_GPIO_ONE = 3'b001,
    MODE_GPIO_TWO = 3'b010,
    MODE_GPIO_FOUR = 3'b011,
    MODE_RSVD_A = 3'b100,
    MODE_RSVD_B = 3'b101,
    MODE_SPI_FWD = 3'b110,
    MODE_SPI_REV = 3'b111
  } ctrl_mode_e;
endpackage
`default_nettype wire

/* rtl/remote_cap_regs.sv */
// Behaviour
// - mode low bit held in bit 6
// - load capabilities after receive lock detected
// - two port copies, second port select
// - bit 5 drives frequency training pattern
// - bit 4 drives equalization training pattern
// - bit 3 reports two-lane support
// - bit 2 gives primary or secondary channel
// - hold bit suppresses automatic loading
// - decode three-bit mode into link modes
`timescale 1ns/100ps
`default_nettype none
module remote_cap_regs
  import cap_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] rx_lock,
  input wire logic [6:0] rx_cap_p0,
  input wire logic [6:0] rx_cap_p1,
  input wire logic [1:0] rx_mode_hi_p0,
  input wire logic [1:0] rx_mode_hi_p1,
  output logic [1:0] send_frequency_training,
  output logic [1:0] send_equalizer_training,
  output logic [1:0] two_lane_capable,
  output logic [1:0] secondary_channel,
  output logic [5:0] fast_ctrl_channel_mode,
  output logic [1:0] mode_gpio_lines_nz,
  output logic [1:0] mode_spi
);

  // lock pins come from the link receiver domain; capability words are
  // only sampled on the lock edge, after passing the same two sync flops as lock
  logic [1:0] lock_meta_ff, lock_sync_ff, lock_prev_ff;
  logic [1:0] lock_rise;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_meta_ff <= 2'h0;
      lock_sync_ff <= 2'h0;
      lock_prev_ff <= 2'h0;
    end else begin
      lock_meta_ff <= rx_lock;
      lock_sync_ff <= lock_meta_ff;
      lock_prev_ff <= lock_sync_ff;
    end
  end
  assign lock_rise = lock_sync_ff & ~lock_prev_ff;

  // capability words pass the same two flops as lock; the sender settles them
  // before raising lock, so the synced word is whole when the edge is seen.
  // limitation: a word that changes while lock stays high is not reloaded
  logic [6:0] cap_meta_ff [2];
  logic [6:0] cap_sync_ff [2];
  logic [1:0] hi_meta_ff [2];
  logic [1:0] hi_sync_ff [2];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < 2; p++) begin
        cap_meta_ff[p] <= CAP_RESET[6:0];
        cap_sync_ff[p] <= CAP_RESET[6:0];
        hi_meta_ff[p] <= MODE_HI_RESET;
        hi_sync_ff[p] <= MODE_HI_RESET;
      end
    end else begin
      cap_meta_ff[0] <= rx_cap_p0;
      cap_meta_ff[1] <= rx_cap_p1;
      hi_meta_ff[0] <= rx_mode_hi_p0;
      hi_meta_ff[1] <= rx_mode_hi_p1;
      cap_sync_ff <= cap_meta_ff;
      hi_sync_ff <= hi_meta_ff;
    end
  end

  // apb decode
  wire bus_access = psel & penable;
  wire bus_write = bus_access & pwrite & pstrb[0];
  wire hit_first = (paddr == CAP_FIRST_ADDR);
  wire hit_second = (paddr == CAP_SECOND_ADDR);
  wire hit_port = (paddr == PORT_SEL_ADDR);
  wire hit_status = (paddr == LINK_STATUS_ADDR);
  wire hit_any = hit_first | hit_second | hit_port | hit_status;

  logic second_port_select_ff;
  logic [7:0] cap_ff [2];
  logic [1:0] mode_hi_ff [2];
  logic [7:0] nxt_cap [2];
  logic [1:0] nxt_mode_hi [2];
  wire [6:0] rx_cap [2];
  wire [1:0] rx_hi [2];
  // only the second sync flop feeds the loader
  assign rx_cap[0] = cap_sync_ff[0];
  assign rx_cap[1] = cap_sync_ff[1];
  assign rx_hi[0] = hi_sync_ff[0];
  assign rx_hi[1] = hi_sync_ff[1];

  // port select register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) second_port_select_ff <= 1'b0;
    else if (bus_write && hit_port) second_port_select_ff <= pwdata[0];
  end

  // next value per port: software write beats an automatic load
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      nxt_cap[p] = cap_ff[p];
      nxt_mode_hi[p] = mode_hi_ff[p];
      if (lock_rise[p] && !cap_ff[p][HOLD_BIT]) begin
        nxt_cap[p] = {cap_ff[p][HOLD_BIT], rx_cap[p]};
        nxt_mode_hi[p] = rx_hi[p];
      end
      if (bus_write && (second_port_select_ff == (p == 1))) begin
        if (hit_first) nxt_cap[p] = pwdata[7:0];
        if (hit_second) nxt_mode_hi[p] = pwdata[1:0];
      end
    end
  end

  // capability storage, zero until first load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_ff[0] <= CAP_RESET;
      cap_ff[1] <= CAP_RESET;
      mode_hi_ff[0] <= MODE_HI_RESET;
      mode_hi_ff[1] <= MODE_HI_RESET;
    end else begin
      cap_ff[0] <= nxt_cap[0];
      cap_ff[1] <= nxt_cap[1];
      mode_hi_ff[0] <= nxt_mode_hi[0];
      mode_hi_ff[1] <= nxt_mode_hi[1];
    end
  end

  // read mux for the selected port
  wire sel = second_port_select_ff;
  wire [31:0] rd_value =
    hit_first ? {24'h000000, cap_ff[sel]} :
    hit_second ? {30'h00000000, mode_hi_ff[sel]} :
    hit_port ? {31'h00000000, second_port_select_ff} :
    hit_status ? {30'h00000000, lock_sync_ff} : 32'h00000000;

  // apb answers in the access cycle; unmapped addresses error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      prdata <= (psel & ~penable & ~pwrite) ? rd_value : 32'h00000000;
    end
  end

  // mode decode, three bits assembled per port
  function automatic ctrl_mode_e mode_of(input logic [1:0] hi, input logic lo);
    mode_of = ctrl_mode_e'({hi, lo});
  endfunction

  // drive link-facing controls from registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      send_frequency_training <= 2'h0;
      send_equalizer_training <= 2'h0;
      two_lane_capable <= 2'h0;
      secondary_channel <= 2'h0;
      fast_ctrl_channel_mode <= 6'h00;
      mode_gpio_lines_nz <= 2'h0;
      mode_spi <= 2'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        send_frequency_training[p] <= nxt_cap[p][FREQ_BIT];
        send_equalizer_training[p] <= nxt_cap[p][EQ_BIT];
        two_lane_capable[p] <= nxt_cap[p][DUAL_CAP_BIT];
        secondary_channel[p] <= nxt_cap[p][CHANNEL_BIT];
        fast_ctrl_channel_mode[p*3 +: 3] <= {nxt_mode_hi[p], nxt_cap[p][MODE_LSB_BIT]};
        mode_gpio_lines_nz[p] <= mode_of(nxt_mode_hi[p], nxt_cap[p][MODE_LSB_BIT])
          inside {MODE_GPIO_ONE, MODE_GPIO_TWO, MODE_GPIO_FOUR};
        mode_spi[p] <= mode_of(nxt_mode_hi[p], nxt_cap[p][MODE_LSB_BIT])
          inside {MODE_SPI_FWD, MODE_SPI_REV};
      end
    end
  end

  // a held port keeps software values across a fresh lock
  chk_hold_blocks_load:
    assert property (@(posedge pclk) disable iff (!presetn)
      (lock_rise[0] && cap_ff[0][HOLD_BIT] && !bus_write) |=> $stable(cap_ff[0]))
    else $error("held port 0 capabilities changed on lock");

  sequence lock_edge_free0;
    lock_rise[0] && !cap_ff[0][HOLD_BIT] && !bus_write;
  endsequence
  chk_lock_loads:
    assert property (@(posedge pclk) disable iff (!presetn)
      lock_edge_free0 |=> cap_ff[0][6:0] == $past(rx_cap_p0, 3))
    else $error("port 0 not loaded on lock");

  chk_freq_out:
    assert property (@(posedge pclk) disable iff (!presetn)
      send_frequency_training[1] == cap_ff[1][FREQ_BIT])
    else $error("frequency training output mismatch");

  chk_eq_out:
    assert property (@(posedge pclk) disable iff (!presetn)
      send_equalizer_training[0] == cap_ff[0][EQ_BIT])
    else $error("equalization training output mismatch");

  chk_dual_out:
    assert property (@(posedge pclk) disable iff (!presetn)
      two_lane_capable == {cap_ff[1][DUAL_CAP_BIT], cap_ff[0][DUAL_CAP_BIT]})
    else $error("two-lane report mismatch");

  chk_chan_out:
    assert property (@(posedge pclk) disable iff (!presetn)
      secondary_channel[0] == cap_ff[0][CHANNEL_BIT])
    else $error("channel role mismatch");

  chk_mode_bits:
    assert property (@(posedge pclk) disable iff (!presetn)
      fast_ctrl_channel_mode[2:0] == {mode_hi_ff[0], cap_ff[0][MODE_LSB_BIT]})
    else $error("mode low bit misplaced");

  chk_port_write:
    assert property (@(posedge pclk) disable iff (!presetn)
      (bus_write && hit_first && second_port_select_ff && !lock_rise[0])
        |=> $stable(cap_ff[0]) && cap_ff[1] == $past(pwdata[7:0]))
    else $error("write reached wrong port copy");

  chk_spi_decode:
    assert property (@(posedge pclk) disable iff (!presetn)
      mode_spi[0] == (fast_ctrl_channel_mode[2:1] == 2'b11))
    else $error("spi mode decode wrong");

  chk_reset_zero:
    assert property (@(posedge pclk)
      !presetn |-> cap_ff[0] == CAP_RESET && cap_ff[1] == CAP_RESET)
    else $error("capabilities not zero in reset");

  // a fresh lock on port 0 also brings the upper mode bits across
  chk_lock_loads_hi:
    assert property (@(posedge pclk) disable iff (!presetn)
      lock_edge_free0 |=> mode_hi_ff[0] == $past(rx_mode_hi_p0, 3))
    else $error("port 0 mode bits not loaded on lock");

  // port 1 loads on its own lock edge, two sync flops behind the pins
  sequence lock_edge_free1;
    lock_rise[1] && !cap_ff[1][HOLD_BIT] && !bus_write;
  endsequence
  chk_lock_loads_p1:
    assert property (@(posedge pclk) disable iff (!presetn)
      lock_edge_free1 |=> cap_ff[1][6:0] == $past(rx_cap_p1, 3)
        && mode_hi_ff[1] == $past(rx_mode_hi_p1, 3))
    else $error("port 1 not loaded on lock");

  // hold on port 1 must survive its lock edge as well
  chk_hold_blocks_p1:
    assert property (@(posedge pclk) disable iff (!presetn)
      (lock_rise[1] && cap_ff[1][HOLD_BIT] && !bus_write)
        |=> $stable(cap_ff[1]) && $stable(mode_hi_ff[1]))
    else $error("held port 1 capabilities changed on lock");

  // a pin edge reaches the loader as exactly one pulse, so one lock loads once
  sequence lock_pin_seen0;
    $rose(lock_meta_ff[0]);
  endsequence
  sequence one_load_pulse0;
    lock_rise[0] ##1 !lock_rise[0];
  endsequence
  chk_lock_pulse:
    assert property (@(posedge pclk) disable iff (!presetn)
      lock_pin_seen0 |=> one_load_pulse0)
    else $error("lock edge not seen exactly once");

  // the training request follows the freshly loaded word, not a stale one
  chk_freq_load:
    assert property (@(posedge pclk) disable iff (!presetn)
      lock_edge_free0 |=> send_frequency_training[0] == $past(rx_cap_p0[FREQ_BIT], 3))
    else $error("frequency training not taken from lock load");

  // a read with the second port selected returns the second copy
  chk_port_read:
    assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_first && second_port_select_ff)
        |=> prdata == {24'h000000, $past(cap_ff[1])})
    else $error("read returned wrong port copy");

  // port 1 gpio decode covers codes 001, 010 and 011 only
  chk_gpio_decode:
    assert property (@(posedge pclk) disable iff (!presetn)
      mode_gpio_lines_nz[1]
        == (!fast_ctrl_channel_mode[5] && fast_ctrl_channel_mode[4:3] != 2'b00))
    else $error("gpio mode decode wrong");

  // link-facing controls stay quiet while reset is low
  chk_reset_outputs:
    assert property (@(posedge pclk)
      !presetn |-> fast_ctrl_channel_mode == 6'h00 && two_lane_capable == 2'h0)
    else $error("link controls not zero in reset");

endmodule
`default_nettype wire

/* verif/remote_rx_model.sv */
`timescale 1ns/100ps
`default_nettype none
module remote_rx_model (
  input wire logic pclk,
  output logic [1:0] rx_lock,
  output logic [6:0] rx_cap_p0,
  output logic [6:0] rx_cap_p1,
  output logic [1:0] rx_mode_hi_p0,
  output logic [1:0] rx_mode_hi_p1
);
  logic [1:0] held;
  // lines start idle with lock low
  initial begin
    rx_lock = 2'h0;
    held = 2'h0;
    rx_cap_p0 = 7'h2A;
    rx_cap_p1 = 7'h55;
    rx_mode_hi_p0 = 2'h1;
    rx_mode_hi_p1 = 2'h2;
  end
  // released lines toggle so a stale value can never pass as a load
  always @(posedge pclk) begin
    if (!held[0]) rx_cap_p0 <= ~rx_cap_p0;
    if (!held[0]) rx_mode_hi_p0 <= ~rx_mode_hi_p0;
    if (!held[1]) rx_cap_p1 <= ~rx_cap_p1;
    if (!held[1]) rx_mode_hi_p1 <= ~rx_mode_hi_p1;
  end
  task automatic link(input int p, input logic [6:0] c, input logic [1:0] h);
    @(posedge pclk);
    held[p] <= 1'b1;
    @(posedge pclk);
    if (p == 0) begin
      rx_cap_p0 <= c;
      rx_mode_hi_p0 <= h;
    end else begin
      rx_cap_p1 <= c;
      rx_mode_hi_p1 <= h;
    end
    repeat (4) @(posedge pclk);
    rx_lock[p] <= 1'b1;
  endtask
  // losing lock releases the lines
  task automatic drop(input int p);
    @(posedge pclk);
    rx_lock[p] <= 1'b0;
    @(posedge pclk);
    held[p] <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb
  import cap_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [1:0] rx_lock, sft, seq, tlc, sec, gnz, spi, mhi0, mhi1;
  logic [6:0] cap0, cap1, c0, c1;
  logic [5:0] mode;
  logic [33:0] notes[$];
  logic [33:0] nt;
  int err_count = 0;
  int samples_checked = 0;
  int seed = 42933;
  always #10 pclk = ~pclk;
  remote_cap_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_lock(rx_lock), .rx_cap_p0(cap0),
    .rx_cap_p1(cap1), .rx_mode_hi_p0(mhi0), .rx_mode_hi_p1(mhi1),
    .send_frequency_training(sft), .send_equalizer_training(seq), .two_lane_capable(tlc),
    .secondary_channel(sec), .fast_ctrl_channel_mode(mode), .mode_gpio_lines_nz(gnz),
    .mode_spi(spi));
  remote_rx_model rx_u (.pclk(pclk), .rx_lock(rx_lock), .rx_cap_p0(cap0),
    .rx_cap_p1(cap1), .rx_mode_hi_p0(mhi0), .rx_mode_hi_p1(mhi1));
  task automatic close_out;
    $display("compared %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk_bus(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  // expected port levels follow the field positions of the register
  task automatic chk_out(input int p, input logic [6:0] c, input logic [1:0] h);
    logic [2:0] m;
    logic [8:0] e;
    logic [8:0] g;
    m = {h, c[MODE_LSB_BIT]};
    e = {c[FREQ_BIT], c[EQ_BIT], c[DUAL_CAP_BIT], c[CHANNEL_BIT], m,
      m inside {3'b001, 3'b010, 3'b011}, m[2] & m[1]};
    g = {sft[p], seq[p], tlc[p], sec[p], mode[3*p+:3], gnz[p], spi[p]};
    chk_bus("port outputs", {23'h0, e}, {23'h0, g});
  endtask
  // note [33] read flag, [32] error flag, [31:0] read data
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [33:0] n);
    @(posedge pclk);
    notes.push_back(n);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {2'b10, e});
  endtask
  task automatic relock(input int p, input logic [6:0] c, input logic [1:0] h);
    rx_u.drop(p);
    rx_u.link(p, c, h);
    repeat (6) @(posedge pclk);
  endtask
  // each answer is matched against the oldest note
  always @(posedge pclk) begin
    if (pready === 1'b1 && notes.size() == 0) begin
      chk_bus("unasked answer", 32'h0, 32'h1);
    end else if (pready === 1'b1) begin
      nt = notes.pop_front();
      chk_bus("pslverr", {31'h0, nt[32]}, {31'h0, pslverr});
      if (nt[33]) chk_bus("prdata", nt[31:0], prdata);
    end
  end
  // watchdog sized well above the whole sequence
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    close_out;
  end
  initial begin
    // falling edge at time zero, after the initial high, so the async reset is surely seen
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(CAP_FIRST_ADDR, 32'h0);
    rd(CAP_SECOND_ADDR, 32'h0);
    c0 = 7'($random(seed));
    c1 = 7'($random(seed));
    relock(0, c0, 2'h2);
    chk_out(0, c0, 2'h2);
    rd(CAP_FIRST_ADDR, {25'h0, c0});
    rd(CAP_SECOND_ADDR, 32'h2);
    relock(1, c1, 2'h1);
    chk_out(1, c1, 2'h1);
    wr(PORT_SEL_ADDR, 32'h1);
    rd(CAP_FIRST_ADDR, {25'h0, c1});
    wr(PORT_SEL_ADDR, 32'h0);
    rd(CAP_FIRST_ADDR, {25'h0, c0});
    rd(LINK_STATUS_ADDR, 32'h3);
    wr(CAP_FIRST_ADDR, 32'hAA);
    relock(0, ~c0, 2'h0);
    rd(CAP_FIRST_ADDR, 32'hAA);
    chk_out(0, 7'h2A, 2'h2);
    wr(CAP_FIRST_ADDR, 32'h15);
    relock(0, c0 ^ 7'h55, 2'h3);
    rd(CAP_FIRST_ADDR, {25'h0, c0 ^ 7'h55});
    chk_out(0, c0 ^ 7'h55, 2'h3);
    // second port under hold: software values survive a fresh lock
    wr(PORT_SEL_ADDR, 32'h1);
    wr(CAP_FIRST_ADDR, 32'h9C);
    wr(CAP_SECOND_ADDR, 32'h3);
    relock(1, ~c1, 2'h0);
    rd(CAP_FIRST_ADDR, 32'h9C);
    rd(CAP_SECOND_ADDR, 32'h3);
    chk_out(1, 7'h1C, 2'h3);
    wr(PORT_SEL_ADDR, 32'h0);
    // a write without its low byte strobe leaves the register alone
    pstrb <= 4'hE;
    wr(CAP_FIRST_ADDR, 32'h00);
    pstrb <= 4'hF;
    rd(CAP_FIRST_ADDR, {25'h0, c0 ^ 7'h55});
    for (int m = 0; m < 8; m++) begin
      wr(CAP_SECOND_ADDR, m >> 1);
      wr(CAP_FIRST_ADDR, 32'h80 | ((m & 1) << 6));
      @(negedge pclk);
      chk_out(0, 7'((m & 1) << 6), 2'(m >> 1));
    end
    // unmapped places answer with an error
    apb(1'b0, 12'h0FC, 32'h0, {2'b11, 32'h0});
    apb(1'b1, 12'h0F0, 32'hFF, {2'b01, 32'h0});
    // let the last answer reach the watcher before the verdict
    repeat (2) @(posedge pclk);
    chk_bus("answers pending", 32'h0, 32'(notes.size()));
    close_out;
  end
endmodule
`default_nettype wire
